// file: rtl/pect_top.v
// error counters, prbs self-test control and loopback select of a 10/100 phy
`timescale 1ns/1ps
`include "pect_map.vh"
//
// Notes on behaviour
// - false-carrier counter is 8 bits, adds one per false-carrier event
// - false-carrier counter saturates at ffh until cleared
// - false-carrier count passing 7fh raises an interrupt event
// - reading either counter returns the count then clears it
// - receive-error counter counts errors while data valid and an invalid symbol is flagged in the same cycle
// - receive-error counter holds during mii loopback
// - receive-error counter saturates at ffh, interrupt event passing 7fh
// - self-test error counter: mode 0 stops at max, mode 1 pulses and wraps
// - prbs field: off, single packet, checker only, both continuous
// - lock flag reads 1 while checker locked and synced
// - sync-loss flag reads 1 once checker lost sync
// - generator status reads 1 while packets are generated
// - power mode bit resets to 1, reads 0 in active sleep
// - transmit-in-loopback sends mac data to line during 100m mii loopback
// - loopback select is one-hot: pcs in, pcs out, digital, analog, reverse
// - each half-full event reaches interrupt only when its enable is set

module pect_top (
   // clock and reset
   input wire i_sys_clk,
   input wire i_srst,
   // register port
   input wire [`PECT_ADDR_W-1:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [15:0] o_rdata,
   // line-side events and status, from core logic on this clock
   input wire i_false_carrier,
   input wire i_rx_dv,
   input wire i_rx_err,
   input wire i_invalid_sym,
   input wire i_mii_loopback,
   input wire i_speed_100,
   input wire i_active_sleep,
   input wire i_prbs_locked,
   input wire i_prbs_bit_err,
   input wire i_gen_busy,
   // self-test and loopback controls
   output reg o_gen_en,
   output reg o_gen_continuous,
   output reg o_chk_en,
   output reg o_bist_wrap_pulse,
   output reg o_tx_to_line,
   output reg [4:0] o_lb_sel,
   output reg [15:0] o_bist_err_cnt,
   // interrupt
   output reg o_irq
);

   // ==========================================
   // register decode
   wire [4:0] idx = i_addr[6:2];
   wire word_ok = (i_addr[1:0] == 2'h0);
   wire rd_fc = i_rd && word_ok && (idx == `PECT_IDX_FC_CNT);
   wire rd_re = i_rd && word_ok && (idx == `PECT_IDX_RX_ERR_CNT);
   wire wr_st = i_wr && word_ok && (idx == `PECT_IDX_ST_CTRL);
   wire wr_is = i_wr && word_ok && (idx == `PECT_IDX_IRQ_STAT);
   wire wr_im = i_wr && word_ok && (idx == `PECT_IDX_IRQ_MASK);
   wire rd_st = i_rd && word_ok && (idx == `PECT_IDX_ST_CTRL);

   reg [7:0] fc_cnt_r;
   reg [7:0] fc_cnt_nxt;
   reg [7:0] re_cnt_r;
   reg [7:0] re_cnt_nxt;
   reg [15:0] st_ctrl_r;
   reg [15:0] bist_cnt_r;
   reg [15:0] bist_cnt_nxt;
   reg bist_wrap_nxt;
   reg sync_loss_r;
   reg lock_q_r;
   reg [`PECT_IRQ_W-1:0] irq_stat_r;
   reg [`PECT_IRQ_W-1:0] irq_mask_r;
   reg [`PECT_IRQ_W-1:0] irq_evt;

   // ==========================================
   // event qualification
   wire fc_evt = i_false_carrier;
   wire re_evt = i_rx_err && i_rx_dv && i_invalid_sym && !i_mii_loopback;

   wire [1:0] prbs_cfg = st_ctrl_r[`PECT_ST_PRBS_HI:`PECT_ST_PRBS_LO];
   wire chk_on = (prbs_cfg == `PECT_PRBS_CHK) || (prbs_cfg == `PECT_PRBS_BOTH);

   // ==========================================
   // counter next values
   always @* begin
      if (rd_fc) begin
         fc_cnt_nxt = fc_evt ? 8'h01 : 8'h00;
      end else if (fc_evt && fc_cnt_r != `PECT_CNT_MAX) begin
         fc_cnt_nxt = fc_cnt_r + 8'h01;
      end else begin
         fc_cnt_nxt = fc_cnt_r;
      end
      if (rd_re) begin
         re_cnt_nxt = re_evt ? 8'h01 : 8'h00;
      end else if (re_evt && re_cnt_r != `PECT_CNT_MAX) begin
         re_cnt_nxt = re_cnt_r + 8'h01;
      end else begin
         re_cnt_nxt = re_cnt_r;
      end
      bist_wrap_nxt = 1'b0;
      bist_cnt_nxt = bist_cnt_r;
      if (chk_on && i_prbs_bit_err) begin
         if (bist_cnt_r != `PECT_BIST_MAX) begin
            bist_cnt_nxt = bist_cnt_r + 16'h0001;
         end else if (st_ctrl_r[`PECT_ST_CNT_MODE]) begin
            bist_cnt_nxt = 16'h0000;
            bist_wrap_nxt = 1'b1;
         end
      end
   end

   // half-full crossing detected on the step from 7fh to 80h, so only once per fill
   always @* begin
      irq_evt = {`PECT_IRQ_W{1'b0}};
      irq_evt[`PECT_IRQ_FC_HF] = (fc_cnt_r == `PECT_CNT_HALF) && (fc_cnt_nxt > `PECT_CNT_HALF);
      irq_evt[`PECT_IRQ_RX_ERR_HF] = (re_cnt_r == `PECT_CNT_HALF) && (re_cnt_nxt > `PECT_CNT_HALF);
      irq_evt[`PECT_IRQ_BIST_WRAP] = bist_wrap_nxt;
   end

   // ==========================================
   // state registers
   always @(posedge i_sys_clk) begin
      if (i_srst) begin
         fc_cnt_r <= 8'h00;
         re_cnt_r <= 8'h00;
         bist_cnt_r <= 16'h0000;
         st_ctrl_r <= `PECT_ST_RESET;
         sync_loss_r <= 1'b0;
         lock_q_r <= 1'b0;
         irq_stat_r <= {`PECT_IRQ_W{1'b0}};
         irq_mask_r <= {`PECT_IRQ_W{1'b0}};
      end else begin
         fc_cnt_r <= fc_cnt_nxt;
         re_cnt_r <= re_cnt_nxt;
         // restarting the checker starts a fresh error count
         if (wr_st && (i_wdata[`PECT_ST_PRBS_HI:`PECT_ST_PRBS_LO] != prbs_cfg)) begin
            bist_cnt_r <= 16'h0000;
         end else begin
            bist_cnt_r <= bist_cnt_nxt;
         end
         if (wr_st) begin
            st_ctrl_r <= i_wdata & `PECT_ST_WR_MASK;
         end
         lock_q_r <= chk_on && i_prbs_locked;
         if (lock_q_r && !(chk_on && i_prbs_locked)) begin
            sync_loss_r <= 1'b1;
         end else if (rd_st) begin
            sync_loss_r <= 1'b0;
         end
         // set wins over write-one-to-clear
         irq_stat_r <= (irq_stat_r & ~(wr_is ? i_wdata[`PECT_IRQ_W-1:0] : {`PECT_IRQ_W{1'b0}})) | irq_evt;
         if (wr_im) begin
            irq_mask_r <= i_wdata[`PECT_IRQ_W-1:0];
         end
      end
   end

   // ==========================================
   // outputs
   always @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_rdata <= 16'h0000;
         o_gen_en <= 1'b0;
         o_gen_continuous <= 1'b0;
         o_chk_en <= 1'b0;
         o_bist_wrap_pulse <= 1'b0;
         o_tx_to_line <= 1'b0;
         o_lb_sel <= 5'h00;
         o_bist_err_cnt <= 16'h0000;
         o_irq <= 1'b0;
      end else begin
         o_gen_en <= (prbs_cfg == `PECT_PRBS_GEN_ONE) || (prbs_cfg == `PECT_PRBS_BOTH);
         o_gen_continuous <= (prbs_cfg == `PECT_PRBS_BOTH);
         o_chk_en <= chk_on;
         o_bist_wrap_pulse <= bist_wrap_nxt;
         o_bist_err_cnt <= bist_cnt_r;
         o_tx_to_line <= st_ctrl_r[`PECT_ST_TX_IN_LB] && i_mii_loopback && i_speed_100;
         // one-hot loopback select; non one-hot codes select none
         case (st_ctrl_r[`PECT_ST_LB_HI:`PECT_ST_LB_LO])
            `PECT_LB_PCS_IN, `PECT_LB_PCS_OUT, `PECT_LB_DIGITAL, `PECT_LB_ANALOG, `PECT_LB_REVERSE: begin
               o_lb_sel <= st_ctrl_r[`PECT_ST_LB_HI:`PECT_ST_LB_LO];
            end
            default: begin
               o_lb_sel <= 5'h00;
            end
         endcase
         o_irq <= |(irq_stat_r & irq_mask_r);
         // read data, valid only in the cycle after the read strobe
         if (rd_fc) begin
            o_rdata <= {8'h00, fc_cnt_r};
         end else if (rd_re) begin
            o_rdata <= {8'h00, re_cnt_r};
         end else if (rd_st) begin
            o_rdata <= (st_ctrl_r & `PECT_ST_WR_MASK)
                     | ({15'h0000, chk_on && i_prbs_locked} << `PECT_ST_LOCK)
                     | ({15'h0000, sync_loss_r} << `PECT_ST_SYNC_LOSS)
                     | ({15'h0000, i_gen_busy && o_gen_en} << `PECT_ST_GEN_ACT)
                     | ({15'h0000, !i_active_sleep} << `PECT_ST_PWR_NORM);
         end else if (i_rd && word_ok && (idx == `PECT_IDX_IRQ_STAT)) begin
            o_rdata <= {13'h0000, irq_stat_r};
         end else if (i_rd && word_ok && (idx == `PECT_IDX_IRQ_MASK)) begin
            o_rdata <= {13'h0000, irq_mask_r};
         end else begin
            // unmapped or no read: zero
            o_rdata <= 16'h0000;
         end
      end
   end

endmodule // pect_top

// file: rtl/pect_map.vh
// register offsets, field positions, reset values and limits of the error counter / self-test block
`ifndef PECT_MAP_VH
`define PECT_MAP_VH

// ==========================================
// register indices (byte address = 4 * index)
`define PECT_IDX_FC_CNT      5'h14
`define PECT_IDX_RX_ERR_CNT  5'h15
`define PECT_IDX_ST_CTRL     5'h16
`define PECT_IDX_IRQ_STAT    5'h18
`define PECT_IDX_IRQ_MASK    5'h19
`define PECT_ADDR_W          7

// ==========================================
// self-test control field positions
`define PECT_ST_CNT_MODE     14
`define PECT_ST_PRBS_HI      13
`define PECT_ST_PRBS_LO      12
`define PECT_ST_LOCK         11
`define PECT_ST_SYNC_LOSS    10
`define PECT_ST_GEN_ACT      9
`define PECT_ST_PWR_NORM     8
`define PECT_ST_TX_IN_LB     6
`define PECT_ST_LB_HI        4
`define PECT_ST_LB_LO        0
`define PECT_ST_WR_MASK      16'h705f
`define PECT_ST_RESET        16'h0100

// ==========================================
// counter limits
`define PECT_CNT_MAX         8'hff
`define PECT_CNT_HALF        8'h7f
`define PECT_BIST_MAX        16'hffff

// ==========================================
// prbs modes and loopback one-hot codes
`define PECT_PRBS_OFF        2'h0
`define PECT_PRBS_GEN_ONE    2'h1
`define PECT_PRBS_CHK        2'h2
`define PECT_PRBS_BOTH       2'h3
`define PECT_LB_PCS_IN       5'h01
`define PECT_LB_PCS_OUT      5'h02
`define PECT_LB_DIGITAL      5'h04
`define PECT_LB_ANALOG       5'h08
`define PECT_LB_REVERSE      5'h10

// ==========================================
// interrupt status / mask bits
`define PECT_IRQ_RX_ERR_HF   0
`define PECT_IRQ_FC_HF       1
`define PECT_IRQ_BIST_WRAP   2
`define PECT_IRQ_W           3

`endif

// file: verification/pect_top_monitor.sv
// assertion checker for the error counter and self-test block
`timescale 1ns/1ps
// ==========================================
// port watcher
module pect_top_monitor (
   // clock and reset
   input wire i_sys_clk,
   input wire i_srst,
   // watched ports
   input wire i_rd,
   input wire i_wr,
   input wire i_mii_loopback,
   input wire i_speed_100,
   input wire [15:0] o_rdata,
   input wire o_tx_to_line,
   input wire [4:0] o_lb_sel,
   input wire o_gen_en,
   input wire o_gen_continuous,
   input wire o_chk_en,
   input wire o_bist_wrap_pulse,
   input wire [15:0] o_bist_err_cnt,
   input wire o_irq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   // controls may land one or two edges after the write
   sequence recent_write;
      $past(i_wr) || $past(i_wr, 2);
   endsequence
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data not zero outside a read reply");
   tx_line_gate_a: assert property (o_tx_to_line |-> $past(i_mii_loopback && i_speed_100))
      else $error("line transmit without 100M mii loopback");
   lb_onehot_a: assert property ($onehot0(o_lb_sel))
      else $error("loopback select not one-hot");
   lb_by_write_a: assert property ($changed(o_lb_sel) |-> recent_write)
      else $error("loopback select moved without a write");
   prbs_decode_a: assert property (o_gen_continuous == (o_gen_en && o_chk_en))
      else $error("continuous generation decode wrong");
   prbs_by_write_a: assert property ($changed({o_gen_en, o_chk_en}) |-> recent_write)
      else $error("prbs enables moved without a write");
   bist_step_a: assert property ($changed(o_bist_err_cnt) |->
      o_bist_err_cnt == 16'h0000 || o_bist_err_cnt == $past(o_bist_err_cnt) + 16'h0001)
      else $error("self-test count jumped");
   wrap_pulse_a: assert property (o_bist_wrap_pulse |=> !o_bist_wrap_pulse)
      else $error("wrap pulse longer than one cycle");
   irq_clear_a: assert property ($fell(o_irq) |-> recent_write)
      else $error("interrupt dropped without a write");
endmodule // pect_top_monitor

bind pect_top pect_top_monitor pect_top_monitor_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_rd(i_rd),
   .i_wr(i_wr), .i_mii_loopback(i_mii_loopback), .i_speed_100(i_speed_100), .o_rdata(o_rdata),
   .o_tx_to_line(o_tx_to_line), .o_lb_sel(o_lb_sel), .o_gen_en(o_gen_en), .o_gen_continuous(o_gen_continuous),
   .o_chk_en(o_chk_en), .o_bist_wrap_pulse(o_bist_wrap_pulse), .o_bist_err_cnt(o_bist_err_cnt), .o_irq(o_irq));

// file: verification/pect_top_tb.sv
// self-checking bench for the error counter and self-test block
`timescale 1ns/1ps
`include "pect_map.vh"
// ==========================================
// bench top
module pect_top_tb;
   localparam [6:0] A_FC = {`PECT_IDX_FC_CNT, 2'h0};
   localparam [6:0] A_RE = {`PECT_IDX_RX_ERR_CNT, 2'h0};
   localparam [6:0] A_ST = {`PECT_IDX_ST_CTRL, 2'h0};
   localparam [6:0] A_IS = {`PECT_IDX_IRQ_STAT, 2'h0};
   localparam [6:0] A_IM = {`PECT_IDX_IRQ_MASK, 2'h0};
   reg i_sys_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, wrapped = 1'b0;
   reg [6:0] i_addr = 7'h00;
   reg [15:0] i_wdata = 16'h0000, v = 16'h0036;
   reg i_false_carrier = 0, i_rx_dv = 0, i_rx_err = 0, i_invalid_sym = 0, i_mii_loopback = 0;
   reg i_speed_100 = 0, i_active_sleep = 0, i_prbs_locked = 0, i_prbs_bit_err = 0, i_gen_busy = 0;
   wire [15:0] o_rdata, o_bist_err_cnt;
   wire [4:0] o_lb_sel;
   wire o_gen_en, o_gen_continuous, o_chk_en, o_bist_wrap_pulse, o_tx_to_line, o_irq;
   integer errors = 0, samples_checked = 0, fc = 0, re = 0, i;
   pect_top pect_top_i (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_false_carrier(i_false_carrier), .i_rx_dv(i_rx_dv),
      .i_rx_err(i_rx_err), .i_invalid_sym(i_invalid_sym), .i_mii_loopback(i_mii_loopback),
      .i_speed_100(i_speed_100), .i_active_sleep(i_active_sleep), .i_prbs_locked(i_prbs_locked),
      .i_prbs_bit_err(i_prbs_bit_err), .i_gen_busy(i_gen_busy), .o_gen_en(o_gen_en),
      .o_gen_continuous(o_gen_continuous), .o_chk_en(o_chk_en), .o_bist_wrap_pulse(o_bist_wrap_pulse),
      .o_tx_to_line(o_tx_to_line), .o_lb_sel(o_lb_sel), .o_bist_err_cnt(o_bist_err_cnt), .o_irq(o_irq));
   // ==========================================
   // clock, watchdog, helpers
   initial forever #50 i_sys_clk = ~i_sys_clk;
   initial begin
      #7500000;
      errors = errors + 1;
      test_done;
   end
   always @(posedge i_sys_clk) if (o_bist_wrap_pulse) wrapped <= 1'b1;
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task wr(input [6:0] a, input [15:0] d);
      begin
         @(posedge i_sys_clk);
         i_addr <= a;
         i_wdata <= d;
         i_wr <= 1'b1;
         @(posedge i_sys_clk);
         i_wr <= 1'b0;
      end
   endtask
   // reply stands only in the cycle after the read edge
   task rd(input [6:0] a, input [15:0] exp);
      begin
         @(posedge i_sys_clk);
         i_addr <= a;
         i_rd <= 1'b1;
         @(posedge i_sys_clk);
         i_rd <= 1'b0;
         #1;
         chk(o_rdata, exp);
      end
   endtask
   task settle;
      begin
         repeat (2) @(posedge i_sys_clk);
         #1;
      end
   endtask
   task test_done;
      begin
         if (errors == 0 && samples_checked > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (5) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      rd(A_ST, `PECT_ST_RESET);
      wr(A_IM, 16'h0003);
      for (i = 0; i < 2000; i = i + 1) begin
         @(posedge i_sys_clk);
         v = lfsr(v);
         i_false_carrier <= v[0];
         i_rx_dv <= v[1] | v[5];
         i_rx_err <= v[2];
         i_invalid_sym <= v[3] | v[6];
         i_mii_loopback <= v[4];
         if (v[0] && fc < 255) fc = fc + 1;
         if ((v[1] | v[5]) && v[2] && (v[3] | v[6]) && !v[4] && re < 255) re = re + 1;
      end
      @(posedge i_sys_clk);
      {i_false_carrier, i_rx_dv, i_rx_err, i_invalid_sym, i_mii_loopback} <= 5'h00;
      settle;
      chk({15'h0, o_irq}, {15'h0, fc > 127 || re > 127});
      rd(A_IS, {14'h0, fc > 127, re > 127});
      rd(A_FC, fc[15:0]);
      rd(A_RE, re[15:0]);
      wr(A_IS, 16'h0003);
      settle;
      chk({15'h0, o_irq}, 16'h0000);
      // event on the clearing read edge
      @(posedge i_sys_clk);
      i_addr <= A_FC;
      i_rd <= 1'b1;
      i_false_carrier <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      i_false_carrier <= 1'b0;
      #1;
      chk(o_rdata, 16'h0000);
      rd(A_FC, 16'h0001);
      wr(A_FC, 16'h00aa);
      rd(A_FC, 16'h0000);
      wr(A_ST, 16'hffff);
      rd(A_ST, 16'h715f);
      chk({11'h0, o_lb_sel}, 16'h0000);
      for (i = 0; i < 4; i = i + 1) begin
         wr(A_ST, {2'h0, i[1:0], 12'h000});
         settle;
         chk({13'h0, o_gen_en, o_gen_continuous, o_chk_en}, {13'h0, i == 1 || i == 3, i == 3, i > 1});
      end
      @(posedge i_sys_clk) i_mii_loopback <= 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
         @(posedge i_sys_clk) i_speed_100 <= i[0];
         wr(A_ST, {9'h0, 2'h2, i < 5 ? 5'h01 << i : 5'h03});
         settle;
         chk({10'h0, o_tx_to_line, o_lb_sel}, {10'h0, i[0], i < 5 ? 5'h01 << i : 5'h00});
      end
      @(posedge i_sys_clk);
      {i_active_sleep, i_prbs_locked, i_gen_busy} <= 3'h7;
      wr(A_ST, 16'h1000);
      rd(A_ST, 16'h1200);
      wr(A_ST, 16'h2000);
      @(posedge i_sys_clk) i_prbs_locked <= 1'b0;
      settle;
      rd(A_ST, 16'h2400);
      rd(A_ST, 16'h2000);
      // counter mode 1 (checker only) must wrap and pulse
      wr(A_ST, 16'h6000);
      @(posedge i_sys_clk) i_prbs_bit_err <= 1'b1;
      repeat (65540) @(posedge i_sys_clk);
      i_prbs_bit_err <= 1'b0;
      settle;
      chk({15'h0, wrapped}, 16'h0001);
      chk(o_bist_err_cnt, 16'h0004);
      rd(7'h44, 16'h0000);
      rd(7'h51, 16'h0000);
      test_done;
   end
endmodule // pect_top_tb
